// ### hw/lcw_alu.sv
module lcw_alu
    import lcw_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    // request from decoder
    input  wire logic        REQ_VALID,
    input  wire lcw_req_t    REQ,
    // result to register file
    output logic             RES_VALID,
    output logic             RES_WRITE,
    output logic [15:0]      RES_VALUE,
    output logic             RES_ADDR_ERR,
    // program status
    output lcw_flags_t       FLAGS,
    // interrupt acknowledge permission
    output logic             IRQ_ALLOW
);

    ////////////////////////////////////////////////////////////////////////////
    // operand range checks

    function automatic logic short_ok(input logic [15:0] a, input logic word);
        logic ok;
        ok = 1'b0;
        if (word) begin
            ok = (a >= SHORT_LO) && (a <= SHORT_WORD_HI) && !a[0];
        end else begin
            ok = (a >= SHORT_LO) && (a <= SHORT_BYTE_HI);
        end
        return ok;
    endfunction

    function automatic logic is_word_op(input lcw_op_t o);
        return (o == OP_WORD_ADD) || (o == OP_WORD_SUBTRACT) || (o == OP_WORD_COMPARE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // datapaths

    lcw_res_t   byte_res;
    lcw_res_t   word_res;
    lcw_res_t   sel_res;
    logic       word_op;
    logic       addr_bad;
    logic       known_op;

    lcw_flags_t flags_q;
    logic       res_valid_q;
    logic       res_write_q;
    logic [15:0] res_value_q;
    logic       addr_err_q;
    logic [1:0] irq_hold_q;
    logic       irq_allow_q;

    lcw_byte_unit u_byte (
        .op       (REQ.op),
        .dst      (REQ.dst[7:0]),
        .src      (REQ.src[7:0]),
        .flags_in (flags_q),
        .res      (byte_res)
    );

    lcw_word_unit u_word (
        .op       (REQ.op),
        .dst      (REQ.dst),
        .src      (REQ.src),
        .flags_in (flags_q),
        .res      (word_res)
    );

    assign word_op  = is_word_op(REQ.op);
    assign known_op = (REQ.op != OP_NONE);
    // immediates span the full width, so only short-direct is range checked
    assign addr_bad = (REQ.src_kind == SRC_SHORT) && !short_ok(REQ.short_addr, word_op);
    assign sel_res  = word_op ? word_res : byte_res;

    ////////////////////////////////////////////////////////////////////////////
    // flags

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            flags_q <= FLAGS_RESET;
        end else if (REQ_VALID && known_op && !addr_bad) begin
            flags_q <= sel_res.flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            res_valid_q <= 1'b0;
            res_write_q <= 1'b0;
            res_value_q <= 16'h0000;
            addr_err_q  <= 1'b0;
        end else begin
            res_valid_q <= REQ_VALID && known_op;
            // rejected operands never reach the register file
            res_write_q <= REQ_VALID && known_op && !addr_bad && sel_res.write;
            res_value_q <= sel_res.value;
            addr_err_q  <= REQ_VALID && known_op && addr_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt shadow: the writing instruction and the next one

    // permission kept in its own flop so the port never carries decode glitches
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            irq_hold_q  <= 2'b00;
            irq_allow_q <= 1'b1;
        end else if (REQ_VALID && known_op) begin
            if (REQ.irq_ctl_write) begin
                irq_hold_q  <= 2'b10;
                irq_allow_q <= 1'b0;
            end else begin
                irq_hold_q  <= {1'b0, irq_hold_q[1]};
                irq_allow_q <= !irq_hold_q[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign RES_VALID    = res_valid_q;
    assign RES_WRITE    = res_write_q;
    assign RES_VALUE    = res_value_q;
    assign RES_ADDR_ERR = addr_err_q;
    assign FLAGS        = flags_q;
    assign IRQ_ALLOW    = irq_allow_q;

endmodule

// ### hw/lcw_byte_unit.sv
module lcw_byte_unit
    import lcw_pkg::*;
(
    // operation
    input  wire lcw_op_t    op,
    input  wire logic [7:0] dst,
    input  wire logic [7:0] src,
    input  wire lcw_flags_t flags_in,
    // result
    output lcw_res_t        res
);

    logic [8:0] diff;
    logic [4:0] low_diff;
    logic [7:0] low7_diff;
    logic [7:0] r;

    assign diff      = {1'b0, dst} - {1'b0, src};
    assign low_diff  = {1'b0, dst[3:0]} - {1'b0, src[3:0]};
    assign low7_diff = {1'b0, dst[6:0]} - {1'b0, src[6:0]};

    always_comb begin
        res       = '0;
        res.flags = flags_in;
        r         = 8'h00;
        case (op)
            OP_AND: r = dst & src;
            OP_OR:  r = dst | src;
            OP_XOR: r = dst ^ src;
            default: r = diff[7:0];
        endcase
        if (op == OP_AND || op == OP_OR || op == OP_XOR) begin
            res.value              = {8'h00, r};
            res.write              = 1'b1;
            res.flags.top_bit      = r[BYTE_MSB];
            res.flags.zero         = (r == 8'h00);
            res.flags.parity_ovf   = ~(^r);
            // nibble carry and carry left as they were
        end else if (op == OP_BYTE_COMPARE) begin
            res.write                = 1'b0;
            res.flags.top_bit        = r[BYTE_MSB];
            res.flags.zero           = (r == 8'h00);
            res.flags.nibble_carry   = low_diff[4];
            res.flags.parity_ovf     = low7_diff[7] ^ diff[8];
            res.flags.carry_flag     = diff[8];
        end
    end

endmodule

// ### hw/lcw_pkg.sv
package lcw_pkg;

    typedef enum logic [3:0] {
        OP_NONE          = 4'b0000,
        OP_AND           = 4'b0001,
        OP_OR            = 4'b0010,
        OP_XOR           = 4'b0011,
        OP_BYTE_COMPARE  = 4'b0100,
        OP_WORD_ADD      = 4'b0101,
        OP_WORD_SUBTRACT = 4'b0110,
        OP_WORD_COMPARE  = 4'b0111
    } lcw_op_t;

    typedef enum logic [1:0] {
        SRC_REG    = 2'b00,
        SRC_IMM    = 2'b01,
        SRC_SHORT  = 2'b10,
        SRC_OTHER  = 2'b11
    } lcw_src_t;

    typedef struct packed {
        logic top_bit;
        logic zero;
        logic nibble_carry;
        logic parity_ovf;
        logic carry_flag;
    } lcw_flags_t;

    typedef struct packed {
        lcw_op_t     op;
        lcw_src_t    src_kind;
        logic [15:0] dst;
        logic [15:0] src;
        logic [15:0] short_addr;
        logic        irq_ctl_write;
    } lcw_req_t;

    typedef struct packed {
        logic [15:0] value;
        logic        write;
        lcw_flags_t  flags;
    } lcw_res_t;

    localparam int          BYTE_MSB       = 7;
    localparam int          WORD_MSB       = 15;
    localparam logic [15:0] SHORT_LO       = 16'hfe20;
    localparam logic [15:0] SHORT_BYTE_HI  = 16'hff1f;
    localparam logic [15:0] SHORT_WORD_HI  = 16'hff1e;
    localparam logic [4:0]  FLAGS_RESET    = 5'h00;
    localparam logic        NIBBLE_UNDEF   = 1'b0;

endpackage

// ### hw/lcw_word_unit.sv
module lcw_word_unit
    import lcw_pkg::*;
(
    // operation
    input  wire lcw_op_t     op,
    input  wire logic [15:0] dst,
    input  wire logic [15:0] src,
    input  wire lcw_flags_t  flags_in,
    // result
    output lcw_res_t         res
);

    logic [16:0] sum;
    logic [16:0] diff;
    logic [15:0] low_sum;
    logic [15:0] low_diff;
    logic        is_sub;
    logic [15:0] r;

    assign sum      = {1'b0, dst} + {1'b0, src};
    assign diff     = {1'b0, dst} - {1'b0, src};
    assign low_sum  = {1'b0, dst[14:0]} + {1'b0, src[14:0]};
    assign low_diff = {1'b0, dst[14:0]} - {1'b0, src[14:0]};
    assign is_sub   = (op == OP_WORD_SUBTRACT) || (op == OP_WORD_COMPARE);

    always_comb begin
        res       = '0;
        res.flags = flags_in;
        r         = is_sub ? diff[15:0] : sum[15:0];
        if (op == OP_WORD_ADD) begin
            res.value                = r;
            res.write                = 1'b1;
            res.flags.carry_flag     = sum[16];
            res.flags.parity_ovf     = low_sum[15] ^ sum[16];
        end else if (is_sub) begin
            res.value                = r;
            res.write                = (op == OP_WORD_SUBTRACT);
            res.flags.carry_flag     = diff[16];
            res.flags.parity_ovf     = low_diff[15] ^ diff[16];
        end
        if (op == OP_WORD_ADD || is_sub) begin
            res.flags.top_bit      = r[WORD_MSB];
            res.flags.zero         = (r == 16'h0000);
            // undefined by contract; driven low to keep it deterministic
            res.flags.nibble_carry = NIBBLE_UNDEF;
        end
    end

endmodule

// ### test/lcw_acc_model.sv
module lcw_acc_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // writeback from the datapath
    input  wire logic        res_write,
    input  wire logic [15:0] res_value,
    // destination register contents
    output logic [15:0]      word_accumulator
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_accumulator <= 16'h0000;
        end else if (res_write) begin
            word_accumulator <= res_value;
        end
    end
endmodule

// ### test/lcw_alu_checker.sv
module lcw_alu_checker
    import lcw_pkg::*;
(
    // clock and reset
    input wire logic        CLK_SYS,
    input wire logic        NRST,
    // watched ports
    input wire logic        REQ_VALID,
    input wire lcw_req_t    REQ,
    input wire logic        RES_VALID,
    input wire logic        RES_WRITE,
    input wire logic [15:0] RES_VALUE,
    input wire logic        RES_ADDR_ERR,
    input wire lcw_flags_t  FLAGS,
    input wire logic        IRQ_ALLOW
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    logic go;
    logic lg;
    assign go = REQ_VALID && REQ.op != OP_NONE;
    assign lg = go && REQ.op inside {OP_AND, OP_OR, OP_XOR} && REQ.src_kind != SRC_SHORT;
    a_answer_next: assert property (go |=> RES_VALID) else $error("no answer");
    a_no_extra: assert property (!go |=> !RES_VALID) else $error("spurious answer");
    a_cmp_no_write: assert property (
        go && REQ.op inside {OP_BYTE_COMPARE, OP_WORD_COMPARE} |=> RES_VALID && !RES_WRITE)
        else $error("compare wrote");
    a_and_value: assert property (lg && REQ.op == OP_AND |=>
        RES_VALUE == {8'h00, $past(REQ.dst[7:0]) & $past(REQ.src[7:0])}) else $error("and");
    a_logic_keeps: assert property (lg |=> FLAGS.carry_flag == $past(FLAGS.carry_flag)
        && FLAGS.nibble_carry == $past(FLAGS.nibble_carry)) else $error("flags lost");
    a_zero_flag: assert property (
        RES_WRITE |-> FLAGS.zero == (RES_VALUE == 16'h0000)) else $error("zero flag");
    a_irq_hold: assert property (
        go && REQ.irq_ctl_write |=> !IRQ_ALLOW [*2]) else $error("irq allowed");
    a_short_err: assert property (go && REQ.src_kind == SRC_SHORT
        && REQ.op inside {OP_AND, OP_OR, OP_XOR, OP_BYTE_COMPARE}
        && (REQ.short_addr < SHORT_LO || REQ.short_addr > SHORT_BYTE_HI)
        |=> RES_ADDR_ERR && !RES_WRITE) else $error("bad address taken");
    a_err_keeps: assert property (RES_ADDR_ERR |-> $stable(FLAGS)) else $error("err flags");
    cover property (go && REQ.irq_ctl_write);
    cover property (RES_ADDR_ERR);
    cover property (RES_WRITE && FLAGS.zero);
endmodule

bind lcw_alu lcw_alu_checker i_chk (.CLK_SYS(CLK_SYS), .NRST(NRST), .REQ_VALID(REQ_VALID),
    .REQ(REQ), .RES_VALID(RES_VALID), .RES_WRITE(RES_WRITE), .RES_VALUE(RES_VALUE),
    .RES_ADDR_ERR(RES_ADDR_ERR), .FLAGS(FLAGS), .IRQ_ALLOW(IRQ_ALLOW));

// ### test/tb.sv
module tb;
    import lcw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK_SYS = 1'b0;
    logic        NRST = 1'b0;
    logic        REQ_VALID = 1'b0;
    lcw_req_t    REQ = '0;
    logic        RES_VALID, RES_WRITE, RES_ADDR_ERR, IRQ_ALLOW;
    logic [15:0] RES_VALUE, acc;
    lcw_flags_t  FLAGS;
    int          n_fail = 0;
    int          checked = 0;
    always #2.5 CLK_SYS = ~CLK_SYS;
    lcw_alu i_dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .REQ_VALID(REQ_VALID), .REQ(REQ),
        .RES_VALID(RES_VALID), .RES_WRITE(RES_WRITE), .RES_VALUE(RES_VALUE),
        .RES_ADDR_ERR(RES_ADDR_ERR), .FLAGS(FLAGS), .IRQ_ALLOW(IRQ_ALLOW));
    lcw_acc_model i_acc (.clk(CLK_SYS), .nrst(NRST), .res_write(RES_WRITE),
        .res_value(RES_VALUE), .word_accumulator(acc));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // st: {write, address error}; f: {top, zero, parity_ovf, carry}, nibble carry checked apart
    task run(input lcw_op_t op, input lcw_src_t sk, input logic [15:0] d, input logic [15:0] s,
        input logic [15:0] a, input logic [1:0] st, input logic [15:0] v, input logic [3:0] f);
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b1;
        REQ <= '{op, sk, d, s, a, 1'b0};
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b0;
        #1;
        chk(16'({RES_VALID, RES_WRITE, RES_ADDR_ERR}), 16'({1'b1, st}));
        if (st[1])
            chk(RES_VALUE, v);
        chk(16'({FLAGS.top_bit, FLAGS.zero, FLAGS.parity_ovf, FLAGS.carry_flag}), 16'(f));
    endtask
    task t_logic;
        run(OP_BYTE_COMPARE, SRC_REG, 16'h00, 16'h01, 16'h0, 2'h0, 16'h0, 4'h9);
        run(OP_AND, SRC_REG, 16'h0f, 16'h3c, 16'h0, 2'h2, 16'h0c, 4'h3);
        run(OP_OR, SRC_REG, 16'h80, 16'h01, 16'h0, 2'h2, 16'h81, 4'hb);
        run(OP_XOR, SRC_IMM, 16'h5a, 16'hff, 16'h0, 2'h2, 16'ha5, 4'hb);
        run(OP_AND, SRC_IMM, 16'h0f, 16'hf0, 16'h0, 2'h2, 16'h00, 4'h7);
        run(OP_XOR, SRC_REG, 16'h01, 16'h03, 16'h0, 2'h2, 16'h02, 4'h1);
        chk(16'(FLAGS.nibble_carry), 16'h1);
    endtask
    task t_bcmp;
        run(OP_BYTE_COMPARE, SRC_REG, 16'h80, 16'h01, 16'h0, 2'h0, 16'h0, 4'h2);
        chk(16'(FLAGS.nibble_carry), 16'h1);
        run(OP_BYTE_COMPARE, SRC_IMM, 16'h05, 16'h05, 16'h0, 2'h0, 16'h0, 4'h4);
        chk(16'(FLAGS.nibble_carry), 16'h0);
    endtask
    task t_word;
        run(OP_WORD_ADD, SRC_IMM, 16'h7fff, 16'h1, 16'h0, 2'h2, 16'h8000, 4'ha);
        run(OP_WORD_ADD, SRC_REG, 16'hffff, 16'h1, 16'h0, 2'h2, 16'h0000, 4'h5);
        run(OP_WORD_SUBTRACT, SRC_REG, 16'h8000, 16'h1, 16'h0, 2'h2, 16'h7fff, 4'h2);
        run(OP_WORD_SUBTRACT, SRC_IMM, 16'h0, 16'h1, 16'h0, 2'h2, 16'hffff, 4'h9);
        run(OP_WORD_COMPARE, SRC_REG, 16'h1234, 16'h1234, 16'h0, 2'h0, 16'h0, 4'h4);
        chk(acc, 16'hffff);
    endtask
    task t_addr;
        run(OP_AND, SRC_SHORT, 16'hff, 16'h0f, 16'hff20, 2'h1, 16'h0, 4'h4);
        run(OP_AND, SRC_SHORT, 16'hff, 16'h0f, 16'hff1f, 2'h2, 16'h0f, 4'h2);
        run(OP_BYTE_COMPARE, SRC_SHORT, 16'h1, 16'h1, 16'hfe1f, 2'h1, 16'h0, 4'h2);
        run(OP_WORD_ADD, SRC_SHORT, 16'h1, 16'h1, 16'hff1f, 2'h1, 16'h0, 4'h2);
        run(OP_WORD_ADD, SRC_SHORT, 16'h1, 16'h1, 16'hfe20, 2'h2, 16'h2, 4'h0);
    endtask
    task t_irq;
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b1;
        REQ <= '{OP_AND, SRC_REG, 16'h0, 16'h0, 16'h0, 1'b1};
        @(posedge CLK_SYS);
        REQ.irq_ctl_write <= 1'b0;
        #1 chk(16'(IRQ_ALLOW), 16'h0);
        @(posedge CLK_SYS);
        #1 chk(16'(IRQ_ALLOW), 16'h0);
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b0;
        #1 chk(16'(IRQ_ALLOW), 16'h1);
    endtask
    // an empty slot must not start the shadow; reset mid-run clears results and flags and sets IRQ_ALLOW
    task t_reset;
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b1;
        REQ <= '{OP_NONE, SRC_REG, 16'h0, 16'h0, 16'h0, 1'b1};
        @(posedge CLK_SYS);
        REQ <= '{OP_BYTE_COMPARE, SRC_REG, 16'h0, 16'h1, 16'h0, 1'b1};
        #1 chk(16'({RES_VALID, IRQ_ALLOW}), 16'h1);
        chk(16'({FLAGS.top_bit, FLAGS.zero, FLAGS.parity_ovf, FLAGS.carry_flag}), 16'h6);
        @(posedge CLK_SYS);
        REQ_VALID <= 1'b0;
        NRST <= 1'b0;
        #1 chk(16'({RES_VALID, RES_WRITE, RES_ADDR_ERR, IRQ_ALLOW}), 16'h1);
        chk(16'(FLAGS), 16'(FLAGS_RESET));
        repeat (2) @(posedge CLK_SYS);
        NRST <= 1'b1;
        run(OP_XOR, SRC_IMM, 16'h00, 16'hff, 16'h0, 2'h2, 16'hff, 4'ha);
        chk(16'(FLAGS.nibble_carry), 16'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        n_fail++;
        summarize;
    end
    initial begin
        repeat (8) @(posedge CLK_SYS);
        NRST <= 1'b1;
        #1 chk(16'(IRQ_ALLOW), 16'h1);
        t_logic;
        t_bcmp;
        t_word;
        t_addr;
        t_irq;
        t_reset;
        summarize;
    end
endmodule
